// ==== vic_pkg.sv ====
// constants and register map of the vectored interrupt controller
package vic_pkg;

    localparam int NFLAG = 10;
    localparam int NPRIO = 11;
    localparam int NSRC = 5;
    localparam int DEPTH_W = 4;
    localparam int EVENT_W = 2;

    localparam logic [15:0] FLAG_OFFSET [NFLAG] = '{
        16'h0800, 16'h0802, 16'h0806, 16'h0808, 16'h080a,
        16'h080c, 16'h080e, 16'h0812, 16'h0814, 16'h0816};
    localparam logic [15:0] ENABLE_OFFSET [NFLAG] = '{
        16'h0820, 16'h0822, 16'h0826, 16'h0828, 16'h082a,
        16'h082c, 16'h082e, 16'h0832, 16'h0834, 16'h0836};
    // implemented bits, shared by flag and enable registers
    localparam logic [15:0] FLAG_MASK [NFLAG] = '{
        16'hbf8f, 16'h201f, 16'h0200, 16'h0202, 16'hc000,
        16'hc081, 16'h003f, 16'h2780, 16'h2000, 16'h000e};
    localparam logic [15:0] FLAG_RESET = 16'h0000;

    localparam logic [15:0] PRIO_OFFSET [NPRIO] = '{
        16'h0840, 16'h0842, 16'h0844, 16'h0846, 16'h0848,
        16'h084a, 16'h084e, 16'h085c, 16'h088c, 16'h0896,
        16'h0898};
    localparam logic [15:0] PRIO_RESET [NPRIO] = '{
        16'h4444, 16'h4000, 16'h4444, 16'h4044, 16'h4444,
        16'h0004, 16'h0040, 16'h0040, 16'h0444, 16'h0040,
        16'h4440};

    localparam logic [15:0] CONTROL_OFFSET = 16'h0880;
    localparam logic [15:0] EVENT_STATUS_OFFSET = 16'h0882;
    localparam logic [15:0] EVENT_MASK_OFFSET = 16'h0884;
    localparam logic [15:0] CONTROL_MASK = 16'hffd0;
    localparam logic [15:0] CONTROL_ERR_MASK = 16'h78d0;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    localparam int NEST_BIT = 15;
    localparam int OVA_ERR_BIT = 14;
    localparam int OVB_ERR_BIT = 13;
    localparam int COVA_ERR_BIT = 12;
    localparam int COVB_ERR_BIT = 11;
    localparam int OVA_EN_BIT = 10;
    localparam int OVB_EN_BIT = 9;
    localparam int COV_EN_BIT = 8;
    localparam int SHIFT_ERR_BIT = 7;
    localparam int DIV_ERR_BIT = 6;
    localparam int MATH_ERR_BIT = 4;

    localparam int EV_REQUEST = 0;
    localparam int EV_TRAP = 1;

    // arbitrated sources, listed in rising vector order
    localparam int SRC_FLAG_REG [NSRC] = '{7, 8, 9, 9, 9};
    localparam int SRC_BIT [NSRC] = '{8, 13, 1, 2, 3};
    localparam int SRC_PRIO_REG [NSRC] = '{8, 9, 10, 10, 10};
    localparam int SRC_PRIO_SHIFT [NSRC] = '{0, 4, 4, 8, 12};
    localparam logic [7:0] SRC_VECTOR [NSRC] = '{
        8'ha0, 8'hb5, 8'hb9, 8'hba, 8'hbb};
    localparam logic [7:0] SRC_IRQ [NSRC] = '{
        8'h98, 8'had, 8'hb1, 8'hb2, 8'hb3};
    localparam logic [23:0] SRC_ADDR [NSRC] = '{
        24'h000144, 24'h00016e, 24'h000176, 24'h000178,
        24'h00017a};

endpackage

// ==== vectored_priority_interrupt_controller.sv ====
// vectored priority interrupt controller with trap control register
module vectored_priority_interrupt_controller
    import vic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    input wire logic [NFLAG-1:0][15:0] source_events,
    input wire logic [2:0] cpu_level,
    input wire logic irq_ack,
    input wire logic isr_return,
    input wire logic acc_a_overflow,
    input wire logic acc_b_overflow,
    input wire logic acc_a_catastrophic,
    input wire logic acc_b_catastrophic,
    input wire logic shift_error,
    input wire logic divide_error,
    output logic irq_request,
    output logic [7:0] irq_vector,
    output logic [7:0] irq_number,
    output logic [23:0] irq_address,
    output logic [2:0] irq_level,
    output logic trap_request,
    output logic event_irq
);

    typedef struct packed {
        logic [NFLAG-1:0][15:0] flags;
        logic [NFLAG-1:0][15:0] enables;
        logic [NPRIO-1:0][15:0] prio;
        logic [15:0] control;
        logic [DEPTH_W-1:0] depth;
        logic [EVENT_W-1:0] ev_status;
        logic [EVENT_W-1:0] ev_mask;
        logic [15:0] rd_data;
        logic irq_request;
        logic [7:0] irq_vector;
        logic [7:0] irq_number;
        logic [23:0] irq_address;
        logic [2:0] irq_level;
        logic trap_request;
        logic event_irq;
    } state_s;

    state_s st;
    state_s next_st;

    // a field whose reset level is four spans three writable bits
    function automatic logic [15:0] prio_mask(input logic [15:0] rv);
        prio_mask = rv | (rv >> 1) | (rv >> 2);
    endfunction

    function automatic logic [2:0] prio_field(input logic [15:0] r,
                                              input int shift);
        prio_field = r[shift +: 3];
    endfunction

    function automatic logic src_pending(input state_s s,
                                         input int k);
        src_pending = s.flags[SRC_FLAG_REG[k]][SRC_BIT[k]] &&
                      s.enables[SRC_FLAG_REG[k]][SRC_BIT[k]];
    endfunction

    always_comb begin
        logic found;
        logic blocked;
        logic [2:0] best;
        logic [2:0] lvl;
        logic [15:0] rd;
        logic [EVENT_W-1:0] ev;
        logic [EVENT_W-1:0] clr;
        int pick;
        found = 1'b0;
        best = 3'h0;
        lvl = 3'h0;
        rd = 16'h0000;
        ev = '0;
        clr = '0;
        pick = 0;
        blocked = 1'b0;
        next_st = st;

        // flag and enable registers; a hardware set beats a clear
        for (int i = 0; i < NFLAG; i++) begin
            if (wr_en && addr == FLAG_OFFSET[i]) begin
                next_st.flags[i] = wr_data;
            end
            if (wr_en && addr == ENABLE_OFFSET[i]) begin
                next_st.enables[i] = wr_data;
            end
            next_st.flags[i] = (next_st.flags[i] | source_events[i]) &
                               FLAG_MASK[i];
            next_st.enables[i] = next_st.enables[i] &
                                 FLAG_MASK[i];
            if (rd_en && addr == FLAG_OFFSET[i]) begin
                rd = st.flags[i];
            end
            if (rd_en && addr == ENABLE_OFFSET[i]) begin
                rd = st.enables[i];
            end
        end

        for (int p = 0; p < NPRIO; p++) begin
            if (wr_en && addr == PRIO_OFFSET[p]) begin
                next_st.prio[p] = wr_data &
                                  prio_mask(PRIO_RESET[p]);
            end
            if (rd_en && addr == PRIO_OFFSET[p]) begin
                rd = st.prio[p];
            end
        end

        // control register; error flags are set by the core's events
        if (wr_en && addr == CONTROL_OFFSET) begin
            next_st.control = wr_data;
        end
        if (acc_a_overflow && st.control[OVA_EN_BIT]) begin
            next_st.control[OVA_ERR_BIT] = 1'b1;
        end
        if (acc_b_overflow && st.control[OVB_EN_BIT]) begin
            next_st.control[OVB_ERR_BIT] = 1'b1;
        end
        if (acc_a_catastrophic && st.control[COV_EN_BIT]) begin
            next_st.control[COVA_ERR_BIT] = 1'b1;
        end
        if (acc_b_catastrophic && st.control[COV_EN_BIT]) begin
            next_st.control[COVB_ERR_BIT] = 1'b1;
        end
        if (shift_error) begin
            next_st.control[SHIFT_ERR_BIT] = 1'b1;
            next_st.control[MATH_ERR_BIT] = 1'b1;
        end
        if (divide_error) begin
            next_st.control[DIV_ERR_BIT] = 1'b1;
            next_st.control[MATH_ERR_BIT] = 1'b1;
        end
        next_st.control = next_st.control & CONTROL_MASK;
        if (rd_en && addr == CONTROL_OFFSET) begin
            rd = st.control;
        end
        next_st.trap_request = |(next_st.control & CONTROL_ERR_MASK);

        // service depth; saturates rather than wraps
        if (irq_ack && !isr_return && !(&st.depth)) begin
            next_st.depth = st.depth + 1'b1;
        end else if (isr_return && !irq_ack && st.depth != '0) begin
            next_st.depth = st.depth - 1'b1;
        end

        // arbitration; strict compare keeps the lowest vector on a tie
        for (int k = 0; k < NSRC; k++) begin
            lvl = prio_field(st.prio[SRC_PRIO_REG[k]], SRC_PRIO_SHIFT[k]);
            if (src_pending(st, k) && lvl > cpu_level &&
                (!found || lvl > best)) begin
                found = 1'b1;
                best = lvl;
                pick = k;
            end
        end
        blocked = st.control[NEST_BIT] && st.depth != '0;
        next_st.irq_request = found && !blocked;
        next_st.irq_level = found ? best : 3'h0;
        next_st.irq_vector = found ? SRC_VECTOR[pick] : 8'h00;
        next_st.irq_number = found ? SRC_IRQ[pick] : 8'h00;
        next_st.irq_address = found ? SRC_ADDR[pick] : 24'h000000;

        // sticky event status, write one to clear, set wins
        ev[EV_REQUEST] = next_st.irq_request && !st.irq_request;
        ev[EV_TRAP] = next_st.trap_request && !st.trap_request;
        if (wr_en && addr == EVENT_STATUS_OFFSET) begin
            clr = wr_data[EVENT_W-1:0];
        end
        if (wr_en && addr == EVENT_MASK_OFFSET) begin
            next_st.ev_mask = wr_data[EVENT_W-1:0];
        end
        next_st.ev_status = (st.ev_status & ~clr) | ev;
        next_st.event_irq = |(next_st.ev_status & next_st.ev_mask);
        if (rd_en && addr == EVENT_STATUS_OFFSET) begin
            rd = {{(16-EVENT_W){1'b0}}, st.ev_status};
        end
        if (rd_en && addr == EVENT_MASK_OFFSET) begin
            rd = {{(16-EVENT_W){1'b0}}, st.ev_mask};
        end
        // read data stands only in the cycle after the strobe
        next_st.rd_data = rd;

        if (!rst_n) begin
            next_st = '0;
            for (int i = 0; i < NFLAG; i++) begin
                next_st.flags[i] = FLAG_RESET;
                next_st.enables[i] = FLAG_RESET;
            end
            for (int p = 0; p < NPRIO; p++) begin
                next_st.prio[p] = PRIO_RESET[p];
            end
            next_st.control = CONTROL_RESET;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign rd_data = st.rd_data;
    assign irq_request = st.irq_request;
    assign irq_vector = st.irq_vector;
    assign irq_number = st.irq_number;
    assign irq_address = st.irq_address;
    assign irq_level = st.irq_level;
    assign trap_request = st.trap_request;
    assign event_irq = st.event_irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_reset_clears_all: assert property (
        disable iff (1'b0)
        $rose(rst_n) |-> (st.flags == '0 && st.enables == '0 &&
                          !irq_request))
        else $error("flags or enables not zero after reset");

    chk_unused_bits_zero: assert property (
        rd_en && addr == FLAG_OFFSET[0] |=>
            (rd_data & ~FLAG_MASK[0]) == 16'h0000)
        else $error("unused flag bits read back nonzero");

    chk_prio_unused_zero: assert property (
        rd_en && addr == PRIO_OFFSET[5] |=>
            (rd_data & ~prio_mask(PRIO_RESET[5])) == 16'h0000)
        else $error("unused priority bits read back nonzero");

    chk_nesting_blocks: assert property (
        st.control[NEST_BIT] && st.depth != '0 |=> !irq_request)
        else $error("request raised while nesting disabled");

    chk_catastrophic_trap: assert property (
        acc_a_catastrophic && st.control[COV_EN_BIT] |=>
            st.control[COVA_ERR_BIT] ##1 trap_request)
        else $error("catastrophic overflow trap missing");

    chk_cov_disabled: assert property (
        acc_b_catastrophic && !st.control[COV_EN_BIT] &&
        !st.control[COVB_ERR_BIT] && !wr_en |=>
            !st.control[COVB_ERR_BIT])
        else $error("catastrophic trap taken while disabled");

    chk_acc_b_overflow: assert property (
        acc_b_overflow && st.control[OVB_EN_BIT] |=>
            st.control[OVB_ERR_BIT])
        else $error("accumulator b overflow trap missing");

    chk_acc_a_disabled: assert property (
        acc_a_overflow && !st.control[OVA_EN_BIT] &&
        !st.control[OVA_ERR_BIT] && !wr_en |=>
            !st.control[OVA_ERR_BIT])
        else $error("accumulator a trap taken while disabled");

    chk_math_status: assert property (
        (shift_error || divide_error) ##1 (rd_en &&
        addr == CONTROL_OFFSET && !wr_en) |=> rd_data[MATH_ERR_BIT])
        else $error("math error status not shown on read");

    chk_collision_vector: assert property (
        irq_request && irq_vector == SRC_VECTOR[1] |->
            irq_address == SRC_ADDR[1] &&
            $past(st.flags[8][13] && st.enables[8][13]))
        else $error("collision vector without its flag");

    chk_comparator0_vec: assert property (
        irq_request && irq_vector == SRC_VECTOR[2] |->
            irq_address == 24'h000176 && $past(st.flags[9][1]))
        else $error("comparator 0 vector mismatch");

    chk_comparator1_vec: assert property (
        irq_request && irq_vector == SRC_VECTOR[3] |->
            irq_address == 24'h000178 && $past(st.enables[9][2]))
        else $error("comparator 1 vector mismatch");

    chk_filter_vector: assert property (
        irq_request && irq_vector == SRC_VECTOR[4] |->
            irq_address == 24'h00017a && $past(st.flags[9][3]))
        else $error("filter vector mismatch");

    chk_channel9_level: assert property (
        irq_request && irq_vector == SRC_VECTOR[0] |->
            irq_level == $past(st.prio[8][2:0]) &&
            irq_address == 24'h000144)
        else $error("channel 9 level or address mismatch");

    chk_request_above_core: assert property (
        irq_request |-> irq_level > $past(cpu_level))
        else $error("request not above core level");

    chk_tie_lowest_vector: assert property (
        irq_request && irq_vector == SRC_VECTOR[3] |->
            !($past(src_pending(st, 2)) &&
              $past(st.prio[10][6:4]) >= irq_level))
        else $error("equal priority tie not won by lower vector");

    chk_read_one_cycle: assert property (
        !rd_en |=> rd_data == 16'h0000)
        else $error("read data stands outside its cycle");

    chk_event_line: assert property (
        $rose(irq_request) && st.ev_mask[EV_REQUEST] |=> event_irq)
        else $error("event interrupt line missing");

endmodule

// ==== core_model.sv ====
// behavioural core that takes and leaves interrupt service on command
module core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic irq_request,
    input wire logic take,
    input wire logic leave,
    input wire logic [3:0] latency,
    output logic irq_ack,
    output logic isr_return
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt;
    logic pend_take;
    logic pend_leave;
    // ack only while a request stands; a slow core may see it vanish
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {irq_ack, isr_return, pend_take, pend_leave} <= 4'h0;
            cnt <= 4'h0;
        end else begin
            irq_ack <= 1'b0;
            isr_return <= 1'b0;
            if (take) pend_take <= 1'b1;
            if (leave) pend_leave <= 1'b1;
            if (pend_take || pend_leave) begin
                cnt <= cnt + 4'h1;
                if (cnt >= latency) begin
                    cnt <= 4'h0;
                    if (pend_take && irq_request) begin
                        irq_ack <= 1'b1;
                        pend_take <= 1'b0;
                    end else if (pend_leave) begin
                        isr_return <= 1'b1;
                        pend_leave <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the vectored priority interrupt controller
`define CHK(nm, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("Error %s expected %h seen %h", nm, e, g); \
    end \
end
module tb_top
    import vic_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n, wr_en, rd_en, irq_ack, isr_return, take, leave;
    logic [15:0] addr, wr_data, rd_data;
    logic [NFLAG-1:0][15:0] source_events;
    logic [2:0] cpu_level, irq_level;
    logic [5:0] trap_in;
    logic [3:0] latency;
    logic irq_request, trap_request, event_irq;
    logic [7:0] irq_vector, irq_number;
    logic [23:0] irq_address;
    int failures = 0;
    int checks_done = 0;
    always #12.5 clk = ~clk;
    vectored_priority_interrupt_controller
        vectored_priority_interrupt_controller_inst (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .source_events(source_events), .cpu_level(cpu_level),
        .irq_ack(irq_ack), .isr_return(isr_return),
        .acc_a_overflow(trap_in[0]), .acc_b_overflow(trap_in[1]),
        .acc_a_catastrophic(trap_in[2]), .acc_b_catastrophic(trap_in[3]),
        .shift_error(trap_in[4]), .divide_error(trap_in[5]),
        .irq_request(irq_request), .irq_vector(irq_vector),
        .irq_number(irq_number), .irq_address(irq_address),
        .irq_level(irq_level), .trap_request(trap_request),
        .event_irq(event_irq));
    core_model core_model_inst (.clk(clk), .rst_n(rst_n),
        .irq_request(irq_request), .take(take), .leave(leave),
        .latency(latency), .irq_ack(irq_ack), .isr_return(isr_return));
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e,
            input string nm);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK(nm, e, rd_data)
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic irq_chk(input logic [7:0] v, input logic [23:0] a,
            input logic [2:0] l);
        settle();
        `CHK("request", 1'b1, irq_request)
        `CHK("vector", v, irq_vector)
        `CHK("number", v - 8'h08, irq_number)
        `CHK("address", a, irq_address)
        `CHK("level", l, irq_level)
    endtask
    task automatic pulse_ev(input int r, input int b);
        @(posedge clk);
        source_events[r][b] <= 1'b1;
        @(posedge clk);
        source_events <= '0;
    endtask
    task automatic pulse_trap(input int k);
        @(posedge clk);
        trap_in[k] <= 1'b1;
        @(posedge clk);
        trap_in <= '0;
    endtask
    // bounded wait for the core's ack or return pulse
    task automatic core_step(input bit out_of_isr, input logic [3:0] lat);
        int n;
        n = 0;
        @(posedge clk);
        latency <= lat;
        take <= !out_of_isr;
        leave <= out_of_isr;
        @(posedge clk);
        take <= 1'b0;
        leave <= 1'b0;
        while (irq_ack !== 1'b1 && isr_return !== 1'b1 && n < 30) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 30) begin
            failures++;
            close_out();
        end
    endtask
    initial begin
        #(25ns * 20000);
        failures++;
        close_out();
    end
    initial begin
        {rst_n, wr_en, rd_en, take, leave} = 5'h0;
        {addr, wr_data} = 32'h0;
        source_events = '0;
        trap_in = '0;
        cpu_level = 3'h0;
        latency = 4'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < NFLAG; i++) begin
            rd(FLAG_OFFSET[i], 16'h0000, "flag reset");
            rd(ENABLE_OFFSET[i], 16'h0000, "enable reset");
        end
        for (int i = 0; i < NPRIO; i++)
            rd(PRIO_OFFSET[i], PRIO_RESET[i], "prio reset");
        rd(CONTROL_OFFSET, 16'h0000, "control reset");
        $display("test reset values done");
        for (int i = 0; i < NFLAG; i++) begin
            wr(FLAG_OFFSET[i], 16'hffff);
            wr(ENABLE_OFFSET[i], 16'hffff);
            rd(FLAG_OFFSET[i], FLAG_MASK[i], "flag bits");
            rd(ENABLE_OFFSET[i], FLAG_MASK[i], "enable bits");
            wr(FLAG_OFFSET[i], 16'h0000);
            wr(ENABLE_OFFSET[i], 16'h0000);
        end
        wr(16'h0818, 16'hffff);
        rd(16'h0818, 16'h0000, "unmapped");
        rd(16'h0800, 16'h0000, "flags cleared");
        $display("test bit masks done");
        wr(ENABLE_OFFSET[8], 16'h2000);
        pulse_ev(8, 13);
        irq_chk(8'hb5, 24'h00016e, 3'h4);
        rd(FLAG_OFFSET[8], 16'h2000, "collision flag");
        wr(ENABLE_OFFSET[9], 16'h000e);
        wr(FLAG_OFFSET[9], 16'h000e);
        irq_chk(8'hb5, 24'h00016e, 3'h4);
        wr(PRIO_OFFSET[10], 16'h4640);
        irq_chk(8'hba, 24'h000178, 3'h6);
        cpu_level <= 3'h6;
        settle();
        `CHK("masked by level", 1'b0, irq_request)
        cpu_level <= 3'h0;
        wr(FLAG_OFFSET[9], 16'h000a);
        irq_chk(8'hb5, 24'h00016e, 3'h4);
        wr(FLAG_OFFSET[8], 16'h0000);
        irq_chk(8'hb9, 24'h000176, 3'h4);
        wr(FLAG_OFFSET[9], 16'h0008);
        irq_chk(8'hbb, 24'h00017a, 3'h4);
        wr(ENABLE_OFFSET[7], 16'h0100);
        wr(FLAG_OFFSET[7], 16'h0100);
        wr(PRIO_OFFSET[8], 16'h0447);
        irq_chk(8'ha0, 24'h000144, 3'h7);
        wr(ENABLE_OFFSET[7], 16'h0000);
        $display("test arbitration done");
        wr(CONTROL_OFFSET, 16'h8000);
        core_step(1'b0, 4'h3);
        settle();
        `CHK("nest blocked", 1'b0, irq_request)
        core_step(1'b1, 4'h0);
        irq_chk(8'hbb, 24'h00017a, 3'h4);
        wr(CONTROL_OFFSET, 16'h0000);
        core_step(1'b0, 4'h0);
        irq_chk(8'hbb, 24'h00017a, 3'h4);
        core_step(1'b1, 4'h2);
        $display("test nesting done");
        wr(CONTROL_OFFSET, 16'h0500);
        pulse_trap(1);
        settle();
        `CHK("b trap off", 1'b0, trap_request)
        pulse_trap(0);
        settle();
        `CHK("a trap", 1'b1, trap_request)
        pulse_trap(3);
        pulse_trap(2);
        pulse_trap(5);
        rd(CONTROL_OFFSET, 16'h5d50, "trap flags");
        // read right behind the error pulse, so the math status check fires
        @(posedge clk);
        trap_in[4] <= 1'b1;
        @(posedge clk);
        trap_in <= '0;
        addr <= CONTROL_OFFSET;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK("shift error", 16'h5dd0, rd_data)
        $display("test traps done");
        rd(EVENT_STATUS_OFFSET, 16'h0003, "event status");
        settle();
        `CHK("event unmasked", 1'b0, event_irq)
        wr(EVENT_MASK_OFFSET, 16'h0003);
        settle();
        `CHK("event raised", 1'b1, event_irq)
        wr(EVENT_STATUS_OFFSET, 16'h0003);
        settle();
        `CHK("event cleared", 1'b0, event_irq)
        rd(EVENT_STATUS_OFFSET, 16'h0000, "status cleared");
        // drop and raise the request again with the event mask open
        wr(FLAG_OFFSET[9], 16'h0000);
        wr(FLAG_OFFSET[9], 16'h0008);
        settle();
        `CHK("event again", 1'b1, event_irq)
        rd(EVENT_STATUS_OFFSET, 16'h0001, "request event");
        $display("test events done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(FLAG_OFFSET[9], 16'h0000, "flag rerun");
        rd(ENABLE_OFFSET[9], 16'h0000, "enable rerun");
        rd(PRIO_OFFSET[10], PRIO_RESET[10], "prio rerun");
        rd(CONTROL_OFFSET, 16'h0000, "control rerun");
        `CHK("request rerun", 1'b0, irq_request)
        $display("test reset rerun done");
        close_out();
    end
endmodule
